// ### design/weld_sequencer_io.sv
// Contact input/output logic and weld sequence of a resistance-weld controller
//
// Contract
// - Program lock closed refuses all setting changes; the interrupt mask stays writable
// - Four select bits choose one of fifteen schedules
// - Optional odd parity check over select inputs
// - Weld enable open: sequence runs without current
// - Step restart returns step number to first
// - Alarm clear resets error and its outputs
// - Switch picks interlock wait or count reset
// - Hold end about 200 ms or start release
// - Option switch: fixed 0.2 s hold-end pulse
// - Hold end also asserted when welding stops
// - Error output on any detected error
// - Step mode: step end after last step
// - Both valves energized whole weld cycle
// - Weld-on output during three weld intervals
// - Interlock output two cycles after power-on
// - Count mode: count-up output at preset
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module weld_sequencer_io #(
  parameter int unsigned HOLD_END_CYC = weld_io_pkg::HOLD_END_CYC,
  parameter int unsigned DEBOUNCE_CYC = weld_io_pkg::DEBOUNCE_CYC,
  parameter int unsigned LINE_CYC     = weld_io_pkg::LINE_CYC
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Contact inputs
  input  wire weld_io_pkg::contacts_s i_contacts,
  // Register port
  input  wire logic [3:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [31:0]                 o_rdata,
  // Contact outputs and interrupt
  output weld_io_pkg::drives_s        o_drives,
  output logic                        o_irq
);
  localparam int NIN = $bits(weld_io_pkg::contacts_s);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Input conditioning
  logic [NIN-1:0] raw;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] clean;
  weld_io_pkg::contacts_s cin;
  logic [31:0] db_cnt [NIN];

  assign raw = i_contacts;
  assign cin = clean;

  genvar g;
  for (g = 0; g < NIN; g++) begin : gen_db
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        sync1[g]  <= 1'b0;
        sync2[g]  <= 1'b0;
        clean[g]  <= 1'b0;
        db_cnt[g] <= 32'h0;
      end else begin
        sync1[g] <= raw[g];
        sync2[g] <= sync1[g];
        // Bounce restarts the count, so one closure yields one edge
        if (sync2[g] == clean[g]) begin
          db_cnt[g] <= 32'h0;
        end else if (db_cnt[g] == 32'(DEBOUNCE_CYC - 1)) begin
          clean[g]  <= sync2[g];
          db_cnt[g] <= 32'h0;
        end else begin
          db_cnt[g] <= db_cnt[g] + 32'h1;
        end
      end
    end
  end

  // Line cycle tick
  logic [31:0] line_cnt;
  logic        tick;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      line_cnt <= 32'h0;
      tick     <= 1'b0;
    end else begin
      tick <= (line_cnt == 32'(LINE_CYC - 1));
      if (line_cnt == 32'(LINE_CYC - 1)) begin
        line_cnt <= 32'h0;
      end else begin
        line_cnt <= line_cnt + 32'h1;
      end
    end
  end

  // Registers
  logic [3:0]  ctrl;
  logic [3:0]  last_step;
  logic [15:0] preset;
  logic [23:0] times;
  logic [7:0]  sched_tbl [16];
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic        cfg_wr;

  assign cfg_wr = i_wr && !cin.prog_lock;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl      <= weld_io_pkg::CTRL_RST;
      last_step <= weld_io_pkg::STEPS_RST;
      preset    <= weld_io_pkg::PRESET_RST;
      times     <= weld_io_pkg::TIMES_RST;
      irq_mask  <= 4'h0;
    end else begin
      if (cfg_wr && i_addr == weld_io_pkg::ADDR_CTRL) begin
        ctrl <= i_wdata[3:0];
      end
      if (cfg_wr && i_addr == weld_io_pkg::ADDR_STEPS) begin
        last_step <= i_wdata[3:0];
      end
      if (cfg_wr && i_addr == weld_io_pkg::ADDR_PRESET) begin
        preset <= i_wdata[15:0];
      end
      if (cfg_wr && i_addr == weld_io_pkg::ADDR_TIMES) begin
        times <= i_wdata[23:0];
      end
      if (i_wr && i_addr == weld_io_pkg::ADDR_MASK) begin
        irq_mask <= i_wdata[3:0];
      end
    end
  end

  chk_lock_refuse: assert property (cin.prog_lock && i_wr |=> ctrl == $past(ctrl) && times == $past(times)
    && last_step == $past(last_step) && preset == $past(preset))
    else $error("setting changed while program lock closed");

  // Per-schedule weld time, written as index in [11:8], value in [7:0]
  for (g = 0; g < 16; g++) begin : gen_sched
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        sched_tbl[g] <= weld_io_pkg::SCHED_RST;
      end else if (cfg_wr && i_addr == weld_io_pkg::ADDR_SCHED && i_wdata[11:8] == 4'(g)) begin
        sched_tbl[g] <= i_wdata[7:0];
      end
    end
  end

  // Start decode
  logic       start;
  logic       start_prev;
  logic       start_rise;
  logic       par_ok;
  logic       ilk_mode;
  logic       ilk_block;
  logic       par_fail;
  logic       go;
  logic [3:0] sched;

  assign start      = |cin.sel;
  assign start_rise = start && !start_prev;
  assign par_ok     = ^{cin.sel, cin.parity};
  assign ilk_mode   = ctrl[weld_io_pkg::CTRL_ILK_MODE];
  assign ilk_block  = ilk_mode && cin.ilk_cnt_reset;
  assign par_fail   = ctrl[weld_io_pkg::CTRL_PARITY_EN] && !par_ok;
  assign go         = start_rise && !o_drives.error && !ilk_block && !par_fail;

  // Sequencer
  weld_io_pkg::seq_state_e state;
  weld_io_pkg::seq_state_e next_state;
  logic [7:0] seq_cnt;
  logic [7:0] next_dur;
  logic       abort;
  logic       done;
  logic       welding;

  assign welding = state inside {weld_io_pkg::ST_WELD1, weld_io_pkg::ST_WELD2, weld_io_pkg::ST_WELD3};
  // Release before hold stops the weld; release during hold is normal
  assign abort = !start && state != weld_io_pkg::ST_IDLE && state != weld_io_pkg::ST_HOLD;
  assign done  = state == weld_io_pkg::ST_HOLD && tick && seq_cnt == 8'h00;

  always_comb begin
    next_state = weld_io_pkg::ST_IDLE;
    next_dur   = 8'h00;
    case (state)
      weld_io_pkg::ST_IDLE: begin
        next_state = weld_io_pkg::ST_SQUEEZE;
        next_dur   = times[7:0];
      end
      weld_io_pkg::ST_SQUEEZE: begin
        next_state = weld_io_pkg::ST_WELD1;
        next_dur   = sched_tbl[sched];
      end
      weld_io_pkg::ST_WELD1: begin
        next_state = weld_io_pkg::ST_COOL1;
        next_dur   = times[15:8];
      end
      weld_io_pkg::ST_COOL1: begin
        next_state = weld_io_pkg::ST_WELD2;
        next_dur   = sched_tbl[sched];
      end
      weld_io_pkg::ST_WELD2: begin
        next_state = weld_io_pkg::ST_COOL2;
        next_dur   = times[15:8];
      end
      weld_io_pkg::ST_COOL2: begin
        next_state = weld_io_pkg::ST_WELD3;
        next_dur   = sched_tbl[sched];
      end
      weld_io_pkg::ST_WELD3: begin
        next_state = weld_io_pkg::ST_HOLD;
        next_dur   = times[23:16];
      end
      weld_io_pkg::ST_HOLD: begin
        next_state = weld_io_pkg::ST_IDLE;
        next_dur   = 8'h00;
      end
      default: begin
        next_state = weld_io_pkg::ST_IDLE;
        next_dur   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state      <= weld_io_pkg::ST_IDLE;
      seq_cnt    <= 8'h00;
      sched      <= 4'h0;
      start_prev <= 1'b0;
    end else begin
      start_prev <= start;
      if (state == weld_io_pkg::ST_IDLE) begin
        if (go) begin
          state   <= next_state;
          seq_cnt <= next_dur;
          sched   <= cin.sel;
        end
      end else if (abort) begin
        state <= weld_io_pkg::ST_IDLE;
      end else if (tick) begin
        if (seq_cnt == 8'h00) begin
          state   <= next_state;
          seq_cnt <= next_dur;
        end else begin
          seq_cnt <= seq_cnt - 8'h01;
        end
      end
    end
  end

  // Error, step and counters
  logic        err;
  logic [3:0]  step;
  logic        step_end;
  logic [15:0] work_cnt;
  logic        count_up;
  logic        ilk_prev;
  logic        cnt_reset;
  logic [1:0]  ilk_lines;

  assign cnt_reset = !ilk_mode && cin.ilk_cnt_reset && !ilk_prev;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err <= 1'b0;
    end else if (state == weld_io_pkg::ST_IDLE && start_rise && par_fail) begin
      err <= 1'b1;
    end else if (cin.error_reset) begin
      err <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      step     <= 4'h0;
      step_end <= 1'b0;
    end else if (cin.step_reset) begin
      step     <= 4'h0;
      step_end <= 1'b0;
    end else if (done && ctrl[weld_io_pkg::CTRL_STEP_MODE]) begin
      if (step == last_step) begin
        step_end <= 1'b1;
      end else begin
        step <= step + 4'h1;
      end
    end
  end

  chk_step_restart: assert property (cin.step_reset |=> step == 4'h0 && !step_end)
    else $error("step not returned to first");

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      work_cnt <= 16'h0000;
      count_up <= 1'b0;
      ilk_prev <= 1'b0;
    end else begin
      ilk_prev <= cin.ilk_cnt_reset;
      if (cnt_reset) begin
        work_cnt <= 16'h0000;
        count_up <= 1'b0;
      end else if (done) begin
        work_cnt <= work_cnt + 16'h0001;
        if (work_cnt + 16'h0001 == preset) begin
          count_up <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ilk_lines <= 2'h0;
    end else if (tick && ilk_lines != 2'(weld_io_pkg::ILK_DELAY_LINES)) begin
      ilk_lines <= ilk_lines + 2'h1;
    end
  end

  // Hold-end timing
  logic [31:0] hold_left;
  logic        hold_full;
  logic        opt;

  assign opt = ctrl[weld_io_pkg::CTRL_HOLD_OPT];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_left <= 32'h0;
      hold_full <= 1'b0;
    end else if ((done || abort) && !err) begin
      hold_left <= 32'(HOLD_END_CYC);
      hold_full <= opt || abort;
    end else if (hold_left != 32'h0) begin
      // Without the option, unless loaded by a stop, a released start ends the contact early
      if (!hold_full && !start) begin
        hold_left <= 32'h0;
      end else begin
        hold_left <= hold_left - 32'h1;
      end
    end
  end

  // Registered contact drives
  weld_io_pkg::drives_s next_drv;

  always_comb begin
    next_drv              = '0;
    next_drv.hold_end     = hold_left != 32'h0;
    next_drv.error        = err;
    next_drv.step_end     = step_end;
    next_drv.valve1       = state != weld_io_pkg::ST_IDLE;
    next_drv.valve2       = state != weld_io_pkg::ST_IDLE;
    next_drv.weld_on      = welding;
    next_drv.fire         = welding && cin.weld_enable;
    next_drv.ilk_count_up = ilk_mode ? (ilk_lines == 2'(weld_io_pkg::ILK_DELAY_LINES)) : count_up;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_drives <= '0;
    end else begin
      o_drives <= next_drv;
    end
  end

  chk_fire_gate: assert property (o_drives.fire |-> o_drives.weld_on && $past(cin.weld_enable))
    else $error("current fired with weld enable open");
  chk_weld_on_interval: assert property ($past(welding) |-> o_drives.weld_on && o_drives.valve1)
    else $error("weld-on missing during weld interval");
  chk_valve_cycle: assert property (o_drives.valve1 == o_drives.valve2
    && o_drives.valve1 == ($past(state) != weld_io_pkg::ST_IDLE)) else $error("valves not following cycle");
  chk_alarm_clear: assert property (cin.error_reset && !(start_rise && par_fail) |-> ##2 !o_drives.error)
    else $error("error output not cleared");
  chk_parity_flag: assert property (state == weld_io_pkg::ST_IDLE && start_rise && par_fail |-> ##2
    o_drives.error && !o_drives.valve1) else $error("parity failure not flagged");
  chk_interlock_wait: assert property (state == weld_io_pkg::ST_IDLE && ilk_block |=>
    state == weld_io_pkg::ST_IDLE) else $error("start taken while interlock closed");
  chk_hold_end_rel: assert property ($fell(o_drives.hold_end) |-> $past(hold_left, 2) == 32'h1
    || ($past(!hold_full, 2) && $past(!start, 2))) else $error("hold end dropped early");
  chk_count_up_mode: assert property (!ilk_mode && $rose(count_up) |=> o_drives.ilk_count_up)
    else $error("count-up not driven at preset");
  chk_stop_hold: assert property (abort && !err |=> hold_full ##1 o_drives.hold_end)
    else $error("hold end missing after stop");

  // Interrupts: set wins over a same-cycle clear
  logic [3:0] events;
  logic [3:0] next_stat;
  logic [3:0] clr;

  assign events = {next_drv.hold_end && !o_drives.hold_end,
                   next_drv.ilk_count_up && !o_drives.ilk_count_up && !ilk_mode,
                   next_drv.step_end && !o_drives.step_end,
                   next_drv.error && !o_drives.error};
  assign clr       = (i_wr && i_addr == weld_io_pkg::ADDR_STAT) ? i_wdata[3:0] : 4'h0;
  assign next_stat = (irq_stat & ~clr) | events;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= 4'h0;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      o_irq    <= |(next_stat & irq_mask);
    end
  end

  // Read port: data valid only in the cycle after the strobe
  logic [31:0] rd_mux;

  always_comb begin
    case (i_addr)
      weld_io_pkg::ADDR_CTRL:   rd_mux = {28'h0, ctrl};
      weld_io_pkg::ADDR_STEPS:  rd_mux = {28'h0, last_step};
      weld_io_pkg::ADDR_PRESET: rd_mux = {16'h0, preset};
      weld_io_pkg::ADDR_SCHED:  rd_mux = {20'h0, sched, sched_tbl[sched]};
      weld_io_pkg::ADDR_TIMES:  rd_mux = {8'h0, times};
      weld_io_pkg::ADDR_STAT:   rd_mux = {28'h0, irq_stat};
      weld_io_pkg::ADDR_MASK:   rd_mux = {28'h0, irq_mask};
      weld_io_pkg::ADDR_STATE:  rd_mux = {work_cnt, step, sched, state};
      default:                  rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
    end
  end
endmodule : weld_sequencer_io

// ### inc/weld_io_pkg.sv
// Shared constants and carrier types for the weld sequencer contact I/O block
package weld_io_pkg;
  // Register word addresses
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_STEPS = 4'h1;
  localparam logic [3:0] ADDR_PRESET = 4'h2;
  localparam logic [3:0] ADDR_SCHED = 4'h3;
  localparam logic [3:0] ADDR_TIMES = 4'h4;
  localparam logic [3:0] ADDR_STAT  = 4'h5;
  localparam logic [3:0] ADDR_MASK  = 4'h6;
  localparam logic [3:0] ADDR_STATE = 4'h7;
  // Control field positions
  localparam int CTRL_PARITY_EN = 0;
  localparam int CTRL_ILK_MODE  = 1;
  localparam int CTRL_HOLD_OPT  = 2;
  localparam int CTRL_STEP_MODE = 3;
  // Interrupt status bit positions
  localparam int IRQ_ERROR = 0;
  localparam int IRQ_STEP  = 1;
  localparam int IRQ_COUNT = 2;
  localparam int IRQ_HOLD  = 3;
  // Reset values
  localparam logic [3:0]  CTRL_RST   = 4'h3;
  localparam logic [3:0]  STEPS_RST  = 4'hf;
  localparam logic [15:0] PRESET_RST = 16'h0000;
  localparam logic [23:0] TIMES_RST  = 24'h050505;
  localparam logic [7:0]  SCHED_RST  = 8'h05;
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned HOLD_END_MS     = 200;
  localparam int unsigned DEBOUNCE_MS     = 5;
  localparam int unsigned LINE_PERIOD_US  = 20000;
  localparam int unsigned ILK_DELAY_LINES = 2;
  localparam int unsigned HOLD_END_CYC = HOLD_END_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LINE_CYC     = LINE_PERIOD_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic       prog_lock;
    logic [3:0] sel;
    logic       parity;
    logic       weld_enable;
    logic       step_reset;
    logic       error_reset;
    logic       ilk_cnt_reset;
  } contacts_s;

  typedef struct packed {
    logic hold_end;
    logic error;
    logic step_end;
    logic valve1;
    logic valve2;
    logic weld_on;
    logic ilk_count_up;
    logic fire;
  } drives_s;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_SQUEEZE = 8'h02,
    ST_WELD1   = 8'h04,
    ST_COOL1   = 8'h08,
    ST_WELD2   = 8'h10,
    ST_COOL2   = 8'h20,
    ST_WELD3   = 8'h40,
    ST_HOLD    = 8'h80
  } seq_state_e;
endpackage : weld_io_pkg

// ### testbench/contact_model.sv
// Machine-side switch contacts: start code with parity, and the other contact lines
`timescale 1ns/1ps
module contact_model (
  // Clock
  input  wire logic              i_clk,
  // Contact lines towards the controller
  output weld_io_pkg::contacts_s o_contacts
);
  initial begin
    o_contacts = '0;
  end

  // Bounce flips every cycle, so it never looks stable long enough to count
  task automatic apply(input weld_io_pkg::contacts_s v);
    weld_io_pkg::contacts_s old;
    old = o_contacts;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      o_contacts <= k[0] ? old : v;
    end
    @(posedge i_clk);
    o_contacts <= v;
  endtask : apply

  // Binary schedule code with its parity line, odd total unless told otherwise
  task automatic set_sel(input logic [3:0] code, input logic good);
    weld_io_pkg::contacts_s v;
    v = o_contacts;
    v.sel = code;
    v.parity = good ? ~^code : ^code;
    apply(v);
  endtask : set_sel
endmodule : contact_model

// ### testbench/tb.sv
// Self-checking bench for the weld sequencer contact I/O block
`timescale 1ns/1ps
module tb;
  localparam int unsigned HOLD = 20;
  logic                   i_clk, i_rst, i_wr, i_rd, o_irq, en;
  logic [3:0]             i_addr, code;
  logic [31:0]            i_wdata, o_rdata, rv;
  weld_io_pkg::contacts_s i_contacts, c;
  weld_io_pkg::drives_s   o_drives;
  int                     errors, n_tests, len;

  weld_sequencer_io #(.HOLD_END_CYC(HOLD), .DEBOUNCE_CYC(2), .LINE_CYC(4)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_contacts(i_contacts), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_drives(o_drives), .o_irq(o_irq));
  contact_model u_ctl (.i_clk(i_clk), .o_contacts(i_contacts));

  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // Bounded wait on one contact output; running out ends the run
  task automatic wait_drv(input int idx, input logic val, input int bound);
    for (int n = 0; n < bound && o_drives[idx] !== val; n++) begin
      tick(1);
    end
    if (o_drives[idx] !== val) begin
      check(32'(o_drives[idx]), 32'(val));
      final_report();
    end
  endtask : wait_drv

  task automatic hold_len();
    len = 0;
    while (o_drives.hold_end === 1'b1 && len < 200) begin
      tick(1);
      len++;
    end
  endtask : hold_len

  task automatic set_line(input int which, input logic v);
    c = i_contacts;
    case (which)
      0: c.prog_lock = v;
      1: c.weld_enable = v;
      2: c.step_reset = v;
      3: c.error_reset = v;
      default: c.ilk_cnt_reset = v;
    endcase
    u_ctl.apply(c);
    tick(6);
  endtask : set_line

  // One weld cycle with start held; returns at the rise of hold end
  task automatic run_weld(input logic [3:0] s, input logic e);
    logic up, vbad, won, fir, fbad;
    {up, vbad, won, fir, fbad} = '0;
    set_line(1, e);
    u_ctl.set_sel(s, 1'b1);
    for (int n = 0; n < 600 && o_drives.hold_end !== 1'b1; n++) begin
      if (o_drives.valve1 && o_drives.valve2) begin
        up = 1'b1;
      end else if (up) begin
        vbad = 1'b1;
      end
      won |= o_drives.weld_on;
      fir |= o_drives.fire;
      fbad |= o_drives.fire & ~o_drives.weld_on;
      tick(1);
    end
    wait_drv(7, 1'b1, 1);
    check({up, vbad}, 32'h2);
    check({won, fir, fbad}, {1'b1, e, 1'b0});
  endtask : run_weld

  task automatic release_start();
    u_ctl.set_sel(4'h0, 1'b1);
    tick(8);
  endtask : release_start

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    check(32'h0, 32'h1);
    final_report();
  end

  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 38'h0};
    errors = 0;
    n_tests = 0;
    rv = $urandom(32'h70df);
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    check(32'(o_drives), 32'h0);
    wait_drv(1, 1'b1, 12);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rv);
      case (a)
        0: check(rv, 32'(weld_io_pkg::CTRL_RST));
        1: check(rv, 32'(weld_io_pkg::STEPS_RST));
        2: check(rv, 32'(weld_io_pkg::PRESET_RST));
        4: check(rv, 32'(weld_io_pkg::TIMES_RST));
        3: check(rv, 32'(weld_io_pkg::SCHED_RST));
        7: check(rv, 32'(weld_io_pkg::ST_IDLE));
        default: check(rv, 32'h0);
      endcase
    end
    wr(weld_io_pkg::ADDR_STATE, 32'hffffffff);
    rd(weld_io_pkg::ADDR_STATE, rv);
    check(rv[7:0], weld_io_pkg::ST_IDLE);
    // Locked settings stay put; unlocked, a shorter timing speeds the run
    set_line(0, 1'b1);
    wr(weld_io_pkg::ADDR_TIMES, 32'h010101);
    rd(weld_io_pkg::ADDR_TIMES, rv);
    check(rv, 32'(weld_io_pkg::TIMES_RST));
    set_line(0, 1'b0);
    wr(weld_io_pkg::ADDR_TIMES, 32'h010101);
    rd(weld_io_pkg::ADDR_TIMES, rv);
    check(rv, 32'h010101);
    for (int i = 0; i < 4; i++) begin
      run_weld(4'h1 << i, 1'b1);
      hold_len();
      check(32'(len), HOLD);
      release_start();
      rd(weld_io_pkg::ADDR_SCHED, rv);
      check(rv[11:8], 4'h1 << i);
    end
    for (int i = 0; i < 6; i++) begin
      code = 4'($urandom_range(15, 1));
      en = 1'($urandom);
      wr(weld_io_pkg::ADDR_CTRL, {29'h0, i[0], 2'b11});
      run_weld(code, en);
      fork
        hold_len();
        u_ctl.set_sel(4'h0, 1'b1);
      join
      check(i[0] ? 32'(len) : 32'(len < HOLD), i[0] ? HOLD : 32'h1);
      tick(8);
      rd(weld_io_pkg::ADDR_SCHED, rv);
      check(rv[11:8], code);
    end
    // Start dropped in mid-weld
    wr(weld_io_pkg::ADDR_CTRL, 32'h3);
    u_ctl.set_sel(4'h3, 1'b1);
    wait_drv(2, 1'b1, 100);
    u_ctl.set_sel(4'h0, 1'b1);
    wait_drv(7, 1'b1, 20);
    check(o_drives.valve1 | o_drives.weld_on, 1'b0);
    hold_len();
    check(32'(len), HOLD);
    tick(4);
    // Parity fault, alarm output, masking and clearing
    wr(weld_io_pkg::ADDR_MASK, 32'h1 << weld_io_pkg::IRQ_ERROR);
    wr(weld_io_pkg::ADDR_STAT, 32'hf);
    tick(2);
    check(o_irq, 1'b0);
    u_ctl.set_sel(4'h5, 1'b0);
    wait_drv(6, 1'b1, 20);
    tick(30);
    check(o_drives.valve1 | o_drives.hold_end, 1'b0);
    check(o_irq, 1'b1);
    wr(weld_io_pkg::ADDR_MASK, 32'h0);
    tick(2);
    check(o_irq, 1'b0);
    wr(weld_io_pkg::ADDR_MASK, 32'h1);
    tick(2);
    check(o_irq, 1'b1);
    release_start();
    set_line(3, 1'b1);
    wait_drv(6, 1'b0, 20);
    set_line(3, 1'b0);
    rd(weld_io_pkg::ADDR_STAT, rv);
    check(rv[weld_io_pkg::IRQ_ERROR], 1'b1);
    wr(weld_io_pkg::ADDR_STAT, 32'h1);
    tick(2);
    check(o_irq, 1'b0);
    // Interlock contact closed blocks a start
    set_line(4, 1'b1);
    u_ctl.set_sel(4'h1, 1'b1);
    tick(40);
    check(o_drives.valve1, 1'b0);
    release_start();
    set_line(4, 1'b0);
    // Step mode ends after the last step, restart clears it
    wr(weld_io_pkg::ADDR_STEPS, 32'h1);
    wr(weld_io_pkg::ADDR_CTRL, 32'hb);
    set_line(2, 1'b1);
    set_line(2, 1'b0);
    for (int i = 0; i < 3 && o_drives.step_end !== 1'b1; i++) begin
      run_weld(4'h2, 1'b1);
      release_start();
    end
    check(o_drives.step_end, 1'b1);
    set_line(2, 1'b1);
    wait_drv(5, 1'b0, 20);
    set_line(2, 1'b0);
    // Count mode: count-up at the preset, count reset clears it
    wr(weld_io_pkg::ADDR_CTRL, 32'h1);
    wr(weld_io_pkg::ADDR_PRESET, 32'h2);
    set_line(4, 1'b1);
    set_line(4, 1'b0);
    check(o_drives.ilk_count_up, 1'b0);
    for (int i = 0; i < 2; i++) begin
      run_weld(4'h4, 1'b0);
      release_start();
      check(o_drives.ilk_count_up, i[0]);
    end
    set_line(4, 1'b1);
    wait_drv(1, 1'b0, 20);
    // Mid-run reset brings back the power-on state and the interlock delay
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    check(32'(o_drives), 32'h0);
    wait_drv(1, 1'b1, 12);
    rd(weld_io_pkg::ADDR_CTRL, rv);
    check(rv, 32'(weld_io_pkg::CTRL_RST));
    final_report();
  end
endmodule : tb
